// File: hdl/standby_map.svh
// Purpose: Register map, field positions and reset values of the standby controller
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Definitions only
`ifndef STANDBY_MAP_SVH
`define STANDBY_MAP_SVH

`define POWER_SAVE_MODE_ADDR  8'h00
`define STANDBY_CONTROL_ADDR  8'h04
`define STAB_TIME_ADDR        8'h08
`define STANDBY_STATUS_ADDR   8'h0C
`define CLOCK_CONFIG_ADDR     8'h10

`define HALT_REQUEST_POS      1
`define MASKABLE_MASK_POS     4
`define NONMASK_MASK_A_POS    5
`define NONMASK_MASK_B_POS    6

`define SEL_STOP_A            2'h1
`define SEL_DEEP_IDLE         2'h2
`define SEL_STOP_B            2'h3

`define STAB_SEL_RESET        3'h4
`define STAB_EXP_BASE         5'h08

`define CFG_SUBCLOCK_POS      0
`define CFG_ITIMER_LSB        1
`define CFG_WATCH_SUB_POS     3
`define ITIMER_FN_DIV8        2'h1
`define ITIMER_SUBCLOCK       2'h2

`define RESP_OKAY             2'h0
`define RESP_DECERR           2'h3

`endif

// File: hdl/standby_pkg.sv
// Purpose: Types shared by the standby controller files
// Assumes: Nothing beyond the map header
// Notes:   Constants live in standby_map.svh
package standby_pkg;

    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_STOP    = 3'b001,
        ST_DEEP_IDLE_MODE   = 3'b010,
        ST_STAB    = 3'b011,
        ST_RSTWAIT = 3'b100
    } state_e;

    typedef struct packed {
        logic nmi_pin;
        logic wdt_irq;
        logic maskable;
    } wake_s;

    typedef struct packed {
        logic main_osc;
        logic sub_osc;
        logic int_osc;
        logic pll;
        logic cpu;
        logic periph;
        logic dma;
        logic gen_timer;
        logic interval_timer;
        logic watch_timer;
        logic ram_retain;
        logic sub_periph;
    } clk_gate_s;

endpackage : standby_pkg

// File: hdl/stab_timer.sv
// Purpose: Oscillation stabilization counter, overflow after 2**exponent cycles
// Assumes: start restarts the count from zero
// Notes:   done is a one-cycle pulse at overflow
`timescale 1ns/1ps
`default_nettype none

module stab_timer
#(
    parameter int CNT_W = 23
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Control
    input  wire logic         start,
    input  wire logic [4:0]   exponent,
    // Status
    output logic              busy,
    output logic              done
);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] limit;

    // Limit captured at start: the exponent source may change while the wait runs
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            limit <= '0;
        end
        else if (start)
        begin
            limit <= (CNT_W'(1) << exponent) - CNT_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst || start)
        begin
            cnt <= '0;
        end
        else if (busy)
        begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            busy <= 1'b0;
        end
        else if (start)
        begin
            busy <= 1'b1;
        end
        else if (busy && cnt == limit)
        begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst || start)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= busy && cnt == limit;
        end
    end

endmodule : stab_timer

`default_nettype wire

// File: hdl/standby_ctrl.sv
// Purpose: STOP and deep-idle standby control with wake-up and stabilization wait
// Assumes: Pins and subclock-side requests are asynchronous; CPU-side inputs share REF_CLK
// Notes:   Registers on AXI4-Lite; outputs are registered
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "standby_map.svh"

module standby_ctrl
    import standby_pkg::*;
#(
    parameter int         N_EXT          = 9,
    parameter logic [4:0] RESET_STAB_EXP = 5'h10
)
(
    // Clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              SRST,
    // AXI4-Lite write
    input  wire logic [7:0]        AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    // AXI4-Lite read
    input  wire logic [7:0]        ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    // Asynchronous wake and reset sources
    input  wire logic              NMI_PIN,
    input  wire logic              WDT_IRQ,
    input  wire logic [N_EXT-1:0]  EXT_IRQ,
    input  wire logic              PERIPH_IRQ,
    input  wire logic              RESET_PIN,
    input  wire logic              WDT_RESET,
    input  wire logic              LVD_RESET,
    // Interrupt controller and CPU state
    input  wire logic              IRQ_PENDING,
    input  wire logic [2:0]        IRQ_LEVEL,
    input  wire logic              INT_ENABLED,
    input  wire logic              ISR_ACTIVE,
    input  wire logic [2:0]        ISR_LEVEL,
    // Clock gating and resume
    output clk_gate_s              CLK_GATES,
    output logic                   STANDBY,
    output logic                   SYS_RESET_REQ,
    output logic                   ACK_HANDLER,
    output logic                   RESUME_NEXT,
    output logic                   KEEP_PENDING
);

    localparam int NPIN = N_EXT + 6;

    state_e            state;
    state_e            next_state;
    logic [NPIN-1:0]   sync1;
    logic [NPIN-1:0]   sync2;
    logic [1:0]        save_select;
    logic              maskable_wake_mask;
    logic              nonmask_wake_mask_a;
    logic              nonmask_wake_mask_b;
    logic [2:0]        stabilization_time_select;
    logic [3:0]        clk_cfg;
    logic              aw_held;
    logic              w_held;
    logic [7:0]        aw_addr;
    logic [7:0]        w_byte;
    logic              wr_fire;
    logic              next_aw_held;
    logic              next_w_held;
    logic              next_rvalid;
    logic              halt_write;
    logic              rst_any;
    wake_s             wake_now;
    wake_s             wake_latch;
    logic              any_wake;
    logic              stab_start;
    logic [4:0]        stab_exp;
    logic              stab_busy;
    logic              stab_done;
    logic              high_prio;
    logic              sub_used;
    logic [1:0]        itimer_sel;

    // Two flops before any logic sees a pin
    always_ff @(posedge REF_CLK)
    begin
        sync1 <= {NMI_PIN, WDT_IRQ, PERIPH_IRQ, EXT_IRQ, RESET_PIN, WDT_RESET, LVD_RESET};
        sync2 <= sync1;
    end

    assign rst_any = |sync2[2:0];
    assign wake_now.nmi_pin  = sync2[NPIN-1] & ~nonmask_wake_mask_a;
    assign wake_now.wdt_irq  = sync2[NPIN-2] & ~nonmask_wake_mask_b;
    assign wake_now.maskable = (|sync2[NPIN-3:3] | IRQ_PENDING) & ~maskable_wake_mask;
    assign any_wake = |(wake_now | wake_latch);
    assign sub_used   = clk_cfg[`CFG_SUBCLOCK_POS];
    assign itimer_sel = clk_cfg[`CFG_ITIMER_LSB +: 2];
    assign high_prio  = !ISR_ACTIVE || (IRQ_LEVEL < ISR_LEVEL);

    // AXI write channel: address and data accepted in either order
    assign wr_fire      = aw_held && w_held && !BVALID;
    assign next_aw_held = (aw_held && !wr_fire) || (AWVALID && AWREADY);
    assign next_w_held  = (w_held && !wr_fire) || (WVALID && WREADY);
    assign next_rvalid  = (ARVALID && ARREADY) || (RVALID && !RREADY);
    assign halt_write   = wr_fire && aw_addr == `STANDBY_CONTROL_ADDR && w_byte[`HALT_REQUEST_POS];

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            AWREADY <= !next_aw_held;
            WREADY  <= !next_w_held;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            aw_addr <= 8'h00;
            w_byte  <= 8'h00;
        end
        else
        begin
            if (AWVALID && AWREADY)
            begin
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY)
            begin
                w_byte <= WSTRB[0] ? WDATA[7:0] : 8'h00;
            end
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            BVALID <= 1'b0;
            BRESP  <= `RESP_OKAY;
        end
        else if (wr_fire)
        begin
            BVALID <= 1'b1;
            BRESP  <= (aw_addr <= `CLOCK_CONFIG_ADDR && aw_addr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_DECERR;
        end
        else if (BREADY)
        begin
            BVALID <= 1'b0;
        end
    end

    // Register writes; the halt request bit is an action, not stored
    always_ff @(posedge REF_CLK)
    begin
        if (SRST || rst_any)
        begin
            save_select               <= 2'h0;
            maskable_wake_mask        <= 1'b0;
            nonmask_wake_mask_a       <= 1'b0;
            nonmask_wake_mask_b       <= 1'b0;
            stabilization_time_select <= `STAB_SEL_RESET;
            clk_cfg                   <= 4'h0;
        end
        else if (wr_fire)
        begin
            case (aw_addr)
                `POWER_SAVE_MODE_ADDR: save_select <= w_byte[1:0];
                `STANDBY_CONTROL_ADDR:
                begin
                    maskable_wake_mask  <= w_byte[`MASKABLE_MASK_POS];
                    nonmask_wake_mask_a <= w_byte[`NONMASK_MASK_A_POS];
                    nonmask_wake_mask_b <= w_byte[`NONMASK_MASK_B_POS];
                end
                `STAB_TIME_ADDR:    stabilization_time_select <= w_byte[2:0];
                `CLOCK_CONFIG_ADDR: clk_cfg <= w_byte[3:0];
                default:            clk_cfg <= clk_cfg;
            endcase
        end
    end

    // AXI read channel
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= `RESP_OKAY;
        end
        else
        begin
            ARREADY <= !next_rvalid;
            RVALID  <= next_rvalid;
            if (ARVALID && ARREADY)
            begin
                RRESP <= `RESP_OKAY;
                case (ARADDR)
                    `POWER_SAVE_MODE_ADDR: RDATA <= {30'h0, save_select};
                    `STANDBY_CONTROL_ADDR: RDATA <= {25'h0, nonmask_wake_mask_b, nonmask_wake_mask_a,
                                                     maskable_wake_mask, 4'h0};
                    `STAB_TIME_ADDR:       RDATA <= {29'h0, stabilization_time_select};
                    `STANDBY_STATUS_ADDR:  RDATA <= {25'h0, wake_latch, stab_busy, state};
                    `CLOCK_CONFIG_ADDR:    RDATA <= {28'h0, clk_cfg};
                    default:
                    begin
                        RDATA <= 32'h0000_0000;
                        RRESP <= `RESP_DECERR;
                    end
                endcase
            end
        end
    end

    // Standby sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN:
            begin
                if (halt_write && (save_select == `SEL_STOP_A || save_select == `SEL_STOP_B))
                begin
                    next_state = ST_STOP;
                end
                else if (halt_write && save_select == `SEL_DEEP_IDLE)
                begin
                    next_state = ST_DEEP_IDLE_MODE;
                end
            end
            ST_STOP, ST_DEEP_IDLE_MODE:
            begin
                if (any_wake)
                begin
                    next_state = ST_STAB;
                end
            end
            ST_STAB, ST_RSTWAIT:
            begin
                if (stab_done)
                begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
        if (rst_any)
        begin
            next_state = ST_RSTWAIT;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            state <= ST_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Clear wins over set; events during run belong to the interrupt controller
    always_ff @(posedge REF_CLK)
    begin
        if (SRST || rst_any || state == ST_RUN)
        begin
            wake_latch <= '0;
        end
        else
        begin
            wake_latch <= wake_latch | wake_now;
        end
    end

    // Restart while reset is held so the full wait follows its release
    assign stab_start = rst_any || ((state == ST_STOP || state == ST_DEEP_IDLE_MODE) && any_wake);
    assign stab_exp   = rst_any ? RESET_STAB_EXP
                                : `STAB_EXP_BASE + {1'b0, stabilization_time_select, 1'b0};

    stab_timer #(
        .CNT_W    (23)
    ) u_stab (
        .clk      (REF_CLK),
        .srst     (SRST),
        .start    (stab_start),
        .exponent (stab_exp),
        .busy     (stab_busy),
        .done     (stab_done)
    );

    // Resume decision once the oscillator is stable
    always_ff @(posedge REF_CLK)
    begin
        if (SRST || !(state == ST_STAB && stab_done && !rst_any))
        begin
            ACK_HANDLER  <= 1'b0;
            RESUME_NEXT  <= 1'b0;
            KEEP_PENDING <= 1'b0;
        end
        else if (wake_latch.nmi_pin || wake_latch.wdt_irq)
        begin
            ACK_HANDLER  <= 1'b1;
        end
        else if (INT_ENABLED && high_prio)
        begin
            ACK_HANDLER  <= 1'b1;
        end
        else
        begin
            RESUME_NEXT  <= 1'b1;
            KEEP_PENDING <= 1'b1;
        end
    end

    // Clock gating follows the current mode and the clock configuration register
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            CLK_GATES     <= '1;
            STANDBY       <= 1'b0;
            SYS_RESET_REQ <= 1'b0;
        end
        else
        begin
            STANDBY       <= state != ST_RUN && state != ST_RSTWAIT;
            SYS_RESET_REQ <= state == ST_RSTWAIT;
            CLK_GATES.main_osc   <= state != ST_STOP;
            CLK_GATES.sub_osc    <= sub_used;
            CLK_GATES.int_osc    <= 1'b1;
            CLK_GATES.pll        <= state == ST_RUN;
            CLK_GATES.cpu        <= state == ST_RUN;
            CLK_GATES.periph     <= state == ST_RUN;
            CLK_GATES.dma        <= state == ST_RUN;
            CLK_GATES.gen_timer  <= state == ST_RUN;
            CLK_GATES.interval_timer <= state == ST_RUN || itimer_sel == `ITIMER_FN_DIV8
                                        || (sub_used && itimer_sel == `ITIMER_SUBCLOCK);
            CLK_GATES.watch_timer <= state == ST_RUN
                                     || (sub_used && clk_cfg[`CFG_WATCH_SUB_POS]);
            CLK_GATES.ram_retain <= 1'b1;
            CLK_GATES.sub_periph <= sub_used;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    sequence s_reset_seen;
        rst_any;
    endsequence

    sequence s_reset_out;
        state == ST_RSTWAIT ##1 SYS_RESET_REQ;
    endsequence

    chk_stop_entry: assert property (state == ST_RUN && halt_write && !rst_any &&
        (save_select == `SEL_STOP_A || save_select == `SEL_STOP_B) |=> state == ST_STOP)
        else $error("halt request with stop select did not enter STOP");
    chk_bad_select: assert property (state == ST_RUN && halt_write && !rst_any &&
        save_select == 2'h0 |=> state == ST_RUN)
        else $error("halt request entered standby with select 00");
    chk_stop_gates: assert property (state == ST_STOP ##1 state == ST_STOP |->
        !CLK_GATES.main_osc && !CLK_GATES.cpu && !CLK_GATES.periph && CLK_GATES.ram_retain)
        else $error("clock gates wrong in STOP");
    chk_pending_wake: assert property (state == ST_STOP && wake_now.maskable && !rst_any
        |=> state == ST_STAB)
        else $error("pending request did not end STOP");
    chk_masked_stays: assert property (state == ST_STOP && !any_wake && !rst_any
        |=> state == ST_STOP)
        else $error("STOP ended without an unmasked request");
    chk_stab_wait: assert property (state == ST_STAB && !stab_done && !rst_any
        |=> state == ST_STAB)
        else $error("normal operation resumed before stabilization");
    chk_nmi_ack: assert property (state == ST_STAB && stab_done && !rst_any && wake_latch.nmi_pin
        |=> ACK_HANDLER && !RESUME_NEXT ##1 state == ST_RUN)
        else $error("non-maskable wake not acknowledged");
    chk_di_next: assert property (state == ST_STAB && stab_done && !rst_any && !INT_ENABLED
        && wake_latch == 3'b001 |=> RESUME_NEXT && KEEP_PENDING && !ACK_HANDLER)
        else $error("disabled maskable wake did not resume at next instruction");
    chk_reset_path: assert property (s_reset_seen |=> s_reset_out)
        else $error("reset did not follow ordinary reset sequence");
    chk_latch_hold: assert property (state == ST_STAB && wake_latch.maskable && !rst_any
        |=> wake_latch.maskable || state == ST_RUN)
        else $error("latched wake event lost during stabilization");

endmodule : standby_ctrl

`default_nettype wire

// File: dv/cpu_intc_model.sv
// Purpose: CPU and interrupt controller side seen by the standby controller
// Assumes: Same clock as the controller, levels change just after an edge
// Notes:   No request is left pending, so entry is never cut short
`timescale 1ns/1ps
`default_nettype none

module cpu_intc_model
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Bench control
    input  wire logic        want_ie,
    input  wire logic        want_isr,
    // Interrupt state
    output logic             IRQ_PENDING,
    output logic [2:0]       IRQ_LEVEL,
    output logic             INT_ENABLED,
    output logic             ISR_ACTIVE,
    output logic [2:0]       ISR_LEVEL
);
    always_ff @(posedge clk)
    begin
        IRQ_PENDING <= 1'b0;
        IRQ_LEVEL   <= 3'h7;
        ISR_ACTIVE  <= want_isr;
        ISR_LEVEL   <= want_isr ? 3'h2 : 3'h7;
        INT_ENABLED <= srst ? 1'b0 : want_ie;
    end
endmodule : cpu_intc_model
`default_nettype wire

// File: dv/test_standby_ctrl.sv
// Purpose: Self-checking bench for STOP entry, wake-up and reset release
// Assumes: Short reset wait (exponent 4), software wait programmed to 2**8
// Notes:   AXI4-Lite master tasks wait on the handshakes, never on fixed delays
`timescale 1ns/1ps
`default_nettype none
`include "standby_map.svh"

module test_standby_ctrl
    import standby_pkg::*;
;
    logic REF_CLK = 1'b0, SRST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic ARVALID = 1'b0, RREADY = 1'b0, NMI_PIN = 1'b0, WDT_IRQ = 1'b0, PERIPH_IRQ = 1'b0;
    logic RESET_PIN = 1'b0, WDT_RESET = 1'b0, LVD_RESET = 1'b0, want_ie = 1'b0, want_isr = 1'b0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [3:0] WSTRB = 4'hF;
    logic [8:0] EXT_IRQ = 9'h000;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, STANDBY, SYS_RESET_REQ;
    logic ACK_HANDLER, RESUME_NEXT, KEEP_PENDING, IRQ_PENDING, INT_ENABLED, ISR_ACTIVE;
    logic [1:0] BRESP, RRESP, rsp;
    logic [2:0] IRQ_LEVEL, ISR_LEVEL, pul;
    logic [31:0] rd_val;
    clk_gate_s CLK_GATES;
    int bad_count = 0, checks_done = 0, n;

    always #20 REF_CLK = ~REF_CLK;

    standby_ctrl #(.RESET_STAB_EXP(5'h04)) dut_u (.*);
    cpu_intc_model u_cpu (.clk(REF_CLK), .srst(SRST), .*);

    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
        for (int i = 0; i < 200; i++)
        begin
            @(posedge REF_CLK);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
            if (BVALID === 1'b1)
            begin
                BREADY <= 1'b0;
                return;
            end
        end
        bad_count++;
        end_of_test();
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge REF_CLK);
        ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
        for (int i = 0; i < 200; i++)
        begin
            @(posedge REF_CLK);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1)
            begin
                d = RDATA; r = RRESP; RREADY <= 1'b0;
                return;
            end
        end
        bad_count++;
        end_of_test();
    endtask : rd

    // Counts cycles from the wake source to the resume pulse
    task wake(output int cnt, output logic [2:0] p);
        for (cnt = 0; cnt < 2000; cnt++)
        begin
            @(posedge REF_CLK);
            p = {ACK_HANDLER, RESUME_NEXT, KEEP_PENDING};
            if ((|p) === 1'b1) return;
        end
        bad_count++;
        end_of_test();
    endtask : wake

    initial
    begin
        repeat (5) @(posedge REF_CLK);
        SRST <= 1'b0;
        @(posedge REF_CLK);
        chk("gates", 32'hFFF, CLK_GATES);
        wr(`STAB_TIME_ADDR, 32'h0);
        wr(`STANDBY_CONTROL_ADDR, 32'h02);
        chk("no stop", 0, STANDBY);
        wr(`POWER_SAVE_MODE_ADDR, 32'h1);
        wr(`STANDBY_CONTROL_ADDR, 32'h22);
        repeat (6) @(posedge REF_CLK);
        chk("standby", 1, STANDBY);
        chk("stop gates", 32'h202, CLK_GATES);
        NMI_PIN <= 1'b1;
        repeat (20) @(posedge REF_CLK);
        NMI_PIN <= 1'b0;
        chk("masked nmi", 1, STANDBY);
        EXT_IRQ <= 9'h001;
        wake(n, pul);
        EXT_IRQ <= 9'h000;
        chk("stab wait", 1, n >= 257 && n <= 275);
        chk("di resume", 32'h3, pul);
        want_ie <= 1'b1;
        wr(`STANDBY_CONTROL_ADDR, 32'h02);
        repeat (6) @(posedge REF_CLK);
        NMI_PIN <= 1'b1;
        wake(n, pul);
        NMI_PIN <= 1'b0;
        chk("nmi resume", 32'h4, pul);
        want_isr <= 1'b1;
        wr(`CLOCK_CONFIG_ADDR, 32'h0B);
        wr(`STANDBY_CONTROL_ADDR, 32'h02);
        repeat (6) @(posedge REF_CLK);
        chk("sub gates", 32'h60F, CLK_GATES);
        EXT_IRQ <= 9'h001;
        wake(n, pul);
        EXT_IRQ <= 9'h000;
        chk("low prio wake", 32'h3, pul);
        want_isr <= 1'b0;
        wr(`STANDBY_CONTROL_ADDR, 32'h02);
        repeat (6) @(posedge REF_CLK);
        RESET_PIN <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        RESET_PIN <= 1'b0;
        @(posedge REF_CLK);
        chk("reset req", 1, SYS_RESET_REQ);
        for (n = 0; n < 100 && SYS_RESET_REQ !== 1'b0; n++) @(posedge REF_CLK);
        chk("reset wait", 1, n >= 14 && n < 100);
        rd(`STAB_TIME_ADDR, rd_val, rsp);
        chk("stab reset", 32'h4, rd_val);
        rd(`STANDBY_STATUS_ADDR, rd_val, rsp);
        chk("state run", 32'h0, rd_val[2:0]);
        rd(8'h40, rd_val, rsp);
        chk("unmapped", `RESP_DECERR, rsp);
        end_of_test();
    end
endmodule : test_standby_ctrl
`default_nettype wire
